// ===== shared/smtc_cfg.svh
// Register map, field positions, reset values and ranges of the speed monitor
`ifndef SMTC_CFG_SVH
`define SMTC_CFG_SVH

`define SMTC_ADDR_W        8
`define SMTC_OFF_CFG       8'h00
`define SMTC_OFF_ROT_LVL   8'h04
`define SMTC_OFF_SPD_LIM   8'h08
`define SMTC_OFF_TRQ_GAIN  8'h0C
`define SMTC_OFF_MOTOR_MAX 8'h10
`define SMTC_OFF_STATUS    8'h14
`define SMTC_OFF_IRQ_STAT  8'h18
`define SMTC_OFF_IRQ_MASK  8'h1C
`define SMTC_OFF_SPD_OUT   8'h20
`define SMTC_OFF_TRQ_OUT   8'h24

`define SMTC_ROT_LVL_RST   16'h0014
`define SMTC_ROT_LVL_MIN   16'h0001
`define SMTC_ROT_LVL_MAX   16'h1388
`define SMTC_SPD_LIM_RST   16'h1388
`define SMTC_SPD_LIM_MIN   16'h0001
`define SMTC_SPD_LIM_MAX   16'h1770
`define SMTC_TRQ_GAIN_RST  16'h0D02
`define SMTC_TRQ_GAIN_MAX  16'h2710
`define SMTC_TRQ_DIV       32'sh00002710

`define SMTC_CFG_MODE_LSB  0
`define SMTC_CFG_MODE_MSB  1
`define SMTC_CFG_LIMSRC    2
`define SMTC_CFG_ESTOP     3
`define SMTC_CFG_W         4

`define SMTC_IRQ_ROT       0
`define SMTC_IRQ_LIM       1
`define SMTC_IRQ_REJ       2
`define SMTC_IRQ_W         3

`define SMTC_RESP_OKAY     2'h0
`define SMTC_RESP_SLVERR   2'h2

`endif

// ===== shared/smtc_pkg.sv
// Types shared by the speed monitor and torque command block
package smtc_pkg;

    // Control modes
    typedef enum logic [1:0] {
        SMTC_MODE_POS,
        SMTC_MODE_SPD,
        SMTC_MODE_TRQ,
        SMTC_MODE_MIX
    } smtc_mode_t;

    // Software configuration word
    typedef struct packed {
        logic       estop_en;
        logic       lim_src;
        smtc_mode_t mode;
    } smtc_cfg_t;

    // Live status word
    typedef struct packed {
        logic estop;
        logic servo_on;
        logic lim_det;
        logic rot_det;
    } smtc_status_t;

    // Bus channel states
    typedef enum logic {
        SMTC_CH_IDLE,
        SMTC_CH_RESP
    } smtc_ch_st_t;

endpackage

// ===== rtl/smtc_cmp.sv
// Registered magnitude comparator of a signed speed against a level
`timescale 1ns/100ps

module smtc_cmp (
    // Clock and control
    input  wire logic               clk_i,
    input  wire logic               srst_i,
    input  wire logic               ce_i,
    input  wire logic               tick_i,
    // Operands
    input  wire logic signed [15:0] speed_i,
    input  wire logic        [15:0] level_i,
    // Results
    output logic                    gt_o,
    output logic                    ge_o
);

    logic [16:0] mag;

    // Magnitude, one bit wider so full negative scale survives
    always_comb begin
        mag = speed_i[15] ? (17'h00000 - {speed_i[15], speed_i}) : {1'b0, speed_i};
    end

    // Compare once per loop cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gt_o <= 1'b0;
            ge_o <= 1'b0;
        end else if (ce_i && tick_i) begin
            gt_o <= mag >  {1'b0, level_i};
            ge_o <= mag >= {1'b0, level_i};
        end
    end

endmodule

// ===== rtl/smtc_trq_scale.sv
// Registered torque command scaler: millivolts times gain over full scale
`timescale 1ns/100ps
`include "smtc_cfg.svh"

module smtc_trq_scale (
    // Clock and control
    input  wire logic               clk_i,
    input  wire logic               srst_i,
    input  wire logic               ce_i,
    input  wire logic               tick_i,
    input  wire logic               active_i,
    // Operands
    input  wire logic signed [15:0] volt_mv_i,
    input  wire logic        [15:0] gain_i,
    // Result in tenths of a percent of rated torque
    output logic signed [15:0]      torque_o
);

    logic signed [31:0] prod;
    logic signed [31:0] quot;

    // Gain is in tenths of percent per ten volts, input in millivolts
    always_comb begin
        prod = 32'(volt_mv_i) * $signed({16'h0000, gain_i});
        quot = prod / `SMTC_TRQ_DIV;
    end

    // Scaled command only while torque mode is active
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            torque_o <= 16'sh0000;
        end else if (ce_i && tick_i) begin
            torque_o <= active_i ? quot[15:0] : 16'sh0000;
        end
    end

endmodule

// ===== rtl/smtc_top.sv
// Speed supervision, speed limiting and torque command scaling with AXI4-Lite registers
`timescale 1ns/100ps
`include "smtc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module smtc_top (
    // Clock, reset, enable
    input  wire logic               CLK_I,
    input  wire logic               SRST_I,
    input  wire logic               CE_I,
    // Drive side
    input  wire logic               LOOP_TICK_I,
    input  wire logic               SERVO_ON_I,
    input  wire logic               ESTOP_I,
    input  wire logic signed [15:0] SPEED_MEAS_I,
    input  wire logic signed [15:0] SPEED_CMD_I,
    input  wire logic        [15:0] HOST_LIMIT_I,
    input  wire logic signed [15:0] TORQUE_MV_I,
    // Sequence outputs and commands
    output logic                    ROT_DETECT_O,
    output logic                    SPD_LIMIT_DETECT_O,
    output logic                    ESTOP_O,
    output logic signed [15:0]      SPEED_CMD_O,
    output logic signed [15:0]      TORQUE_CMD_O,
    output logic                    IRQ_O,
    // AXI4-Lite write address and data
    input  wire logic        [7:0]  S_AXI_AWADDR_I,
    input  wire logic               S_AXI_AWVALID_I,
    output logic                    S_AXI_AWREADY_O,
    input  wire logic        [31:0] S_AXI_WDATA_I,
    input  wire logic        [3:0]  S_AXI_WSTRB_I,
    input  wire logic               S_AXI_WVALID_I,
    output logic                    S_AXI_WREADY_O,
    // AXI4-Lite write response
    output logic             [1:0]  S_AXI_BRESP_O,
    output logic                    S_AXI_BVALID_O,
    input  wire logic               S_AXI_BREADY_I,
    // AXI4-Lite read
    input  wire logic        [7:0]  S_AXI_ARADDR_I,
    input  wire logic               S_AXI_ARVALID_I,
    output logic                    S_AXI_ARREADY_O,
    output logic             [31:0] S_AXI_RDATA_O,
    output logic             [1:0]  S_AXI_RRESP_O,
    output logic                    S_AXI_RVALID_O,
    input  wire logic               S_AXI_RREADY_I
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    smtc_pkg::smtc_cfg_t    cfg_r;
    smtc_pkg::smtc_status_t status;
    smtc_pkg::smtc_ch_st_t  wr_st_r;
    smtc_pkg::smtc_ch_st_t  rd_st_r;
    logic [15:0]            rot_lvl_r;
    logic [15:0]            spd_lim_r;
    logic [15:0]            trq_gain_r;
    logic [`SMTC_IRQ_W-1:0] irq_stat_r;
    logic [`SMTC_IRQ_W-1:0] irq_stat_nxt;
    logic [`SMTC_IRQ_W-1:0] irq_mask_r;
    logic [`SMTC_IRQ_W-1:0] irq_set;
    logic [`SMTC_IRQ_W-1:0] irq_clr;
    logic [7:0]             awaddr_r;
    logic [31:0]            wdata_r;
    logic [3:0]             wstrb_r;
    logic                   aw_held_r;
    logic                   w_held_r;
    logic                   wr_fire;
    logic [15:0]            wval;
    logic                   wr_hit;
    logic                   wr_reject;
    logic [15:0]            eff_limit;
    logic                   clamp_mode;
    logic [16:0]            cmd_mag;
    logic                   rot_q;
    logic                   lim_q;
    logic                   rot_prev_r;
    logic                   lim_prev_r;
    logic [31:0]            rd_word;
    logic                   rd_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Comparators and torque scaler

    // Rotation level, compared strictly greater
    smtc_cmp u_rot_cmp (
        .clk_i   (CLK_I),
        .srst_i  (SRST_I),
        .ce_i    (CE_I),
        .tick_i  (LOOP_TICK_I),
        .speed_i (SPEED_MEAS_I),
        .level_i (rot_lvl_r),
        .gt_o    (rot_q),
        .ge_o    ()
    );

    // Speed limit, compared greater or equal
    smtc_cmp u_lim_cmp (
        .clk_i   (CLK_I),
        .srst_i  (SRST_I),
        .ce_i    (CE_I),
        .tick_i  (LOOP_TICK_I),
        .speed_i (SPEED_MEAS_I),
        .level_i (eff_limit),
        .gt_o    (),
        .ge_o    (lim_q)
    );

    // Torque command from the host differential voltage
    smtc_trq_scale u_trq (
        .clk_i     (CLK_I),
        .srst_i    (SRST_I),
        .ce_i      (CE_I),
        .tick_i    (LOOP_TICK_I),
        .active_i  (cfg_r.mode == smtc_pkg::SMTC_MODE_TRQ),
        .volt_mv_i (TORQUE_MV_I),
        .gain_i    (trq_gain_r),
        .torque_o  (TORQUE_CMD_O)
    );

    assign ROT_DETECT_O       = rot_q;
    assign SPD_LIMIT_DETECT_O = lim_q;

    ////////////////////////////////////////////////////////////////////////////
    // Speed limiting

    // Pick the limit source; the internal value is unused for host source
    always_comb begin
        eff_limit  = cfg_r.lim_src ? HOST_LIMIT_I : spd_lim_r;
        clamp_mode = cfg_r.mode != smtc_pkg::SMTC_MODE_TRQ;
        cmd_mag    = SPEED_CMD_I[15] ? (17'h00000 - {SPEED_CMD_I[15], SPEED_CMD_I})
                                     : {1'b0, SPEED_CMD_I};
    end

    // Clamp the command magnitude, keeping its sign
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            SPEED_CMD_O <= 16'sh0000;
        end else if (CE_I && LOOP_TICK_I) begin
            if (clamp_mode && (cmd_mag > {1'b0, eff_limit})) begin
                SPEED_CMD_O <= SPEED_CMD_I[15] ? -$signed(eff_limit) : $signed(eff_limit);
            end else begin
                SPEED_CMD_O <= SPEED_CMD_I;
            end
        end
    end

    // Emergency stop passes only when enabled
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ESTOP_O <= 1'b0;
        end else if (CE_I) begin
            ESTOP_O <= cfg_r.estop_en & ESTOP_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channel

    // Merge the low two byte lanes into the selected register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // Address and data are taken independently and held until both exist
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            aw_held_r       <= 1'b0;
            w_held_r        <= 1'b0;
            awaddr_r        <= 8'h00;
            wdata_r         <= 32'h00000000;
            wstrb_r         <= 4'h0;
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O  <= 1'b0;
        end else if (CE_I) begin
            S_AXI_AWREADY_O <= !aw_held_r && !(S_AXI_AWVALID_I && S_AXI_AWREADY_O);
            S_AXI_WREADY_O  <= !w_held_r && !(S_AXI_WVALID_I && S_AXI_WREADY_O);
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_held_r <= 1'b1;
                wdata_r  <= S_AXI_WDATA_I;
                wstrb_r  <= S_AXI_WSTRB_I;
            end
            if (wr_fire) begin
                aw_held_r       <= 1'b0;
                w_held_r        <= 1'b0;
                S_AXI_AWREADY_O <= 1'b0;
                S_AXI_WREADY_O  <= 1'b0;
            end
        end
    end

    // Write performed once both halves are held and no response is pending
    always_comb begin
        wr_fire   = aw_held_r && w_held_r && (wr_st_r == smtc_pkg::SMTC_CH_IDLE);
        wr_hit    = 1'b1;
        wr_reject = 1'b0;
        wval      = 16'h0000;
        case (awaddr_r)
            `SMTC_OFF_CFG: begin
            end
            `SMTC_OFF_ROT_LVL: begin
                wval      = merge(rot_lvl_r, wdata_r, wstrb_r);
                wr_reject = (wval < `SMTC_ROT_LVL_MIN) || (wval > `SMTC_ROT_LVL_MAX);
            end
            `SMTC_OFF_SPD_LIM, `SMTC_OFF_MOTOR_MAX: begin
                wval      = merge(spd_lim_r, wdata_r, wstrb_r);
                wr_reject = SERVO_ON_I || (wval < `SMTC_SPD_LIM_MIN)
                            || (wval > `SMTC_SPD_LIM_MAX);
            end
            `SMTC_OFF_TRQ_GAIN: begin
                wval      = merge(trq_gain_r, wdata_r, wstrb_r);
                wr_reject = SERVO_ON_I || (wval > `SMTC_TRQ_GAIN_MAX);
            end
            `SMTC_OFF_STATUS, `SMTC_OFF_IRQ_STAT, `SMTC_OFF_IRQ_MASK,
            `SMTC_OFF_SPD_OUT, `SMTC_OFF_TRQ_OUT: begin
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // Response state
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            wr_st_r        <= smtc_pkg::SMTC_CH_IDLE;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= `SMTC_RESP_OKAY;
        end else if (CE_I) begin
            case (wr_st_r)
                smtc_pkg::SMTC_CH_IDLE: begin
                    if (wr_fire) begin
                        wr_st_r        <= smtc_pkg::SMTC_CH_RESP;
                        S_AXI_BVALID_O <= 1'b1;
                        S_AXI_BRESP_O  <= wr_hit ? `SMTC_RESP_OKAY : `SMTC_RESP_SLVERR;
                    end
                end
                smtc_pkg::SMTC_CH_RESP: begin
                    if (S_AXI_BREADY_I) begin
                        wr_st_r        <= smtc_pkg::SMTC_CH_IDLE;
                        S_AXI_BVALID_O <= 1'b0;
                    end
                end
                default: begin
                    wr_st_r <= smtc_pkg::SMTC_CH_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Control word
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            cfg_r <= '0;
        end else if (CE_I && wr_fire && (awaddr_r == `SMTC_OFF_CFG) && wstrb_r[0]) begin
            cfg_r <= wdata_r[`SMTC_CFG_W-1:0];
        end
    end

    // Rotation level, range checked, any mode
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rot_lvl_r <= `SMTC_ROT_LVL_RST;
        end else if (CE_I && wr_fire && (awaddr_r == `SMTC_OFF_ROT_LVL) && !wr_reject) begin
            rot_lvl_r <= wval;
        end
    end

    // Speed limit, from its own offset or from motor setup
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            spd_lim_r <= `SMTC_SPD_LIM_RST;
        end else if (CE_I && wr_fire && !wr_reject
                     && ((awaddr_r == `SMTC_OFF_SPD_LIM)
                         || (awaddr_r == `SMTC_OFF_MOTOR_MAX))) begin
            spd_lim_r <= wval;
        end
    end

    // Torque gain in tenths
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            trq_gain_r <= `SMTC_TRQ_GAIN_RST;
        end else if (CE_I && wr_fire && (awaddr_r == `SMTC_OFF_TRQ_GAIN) && !wr_reject) begin
            trq_gain_r <= wval;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Rising detects and refused writes are events; set beats clear
    always_comb begin
        irq_set                 = '0;
        irq_set[`SMTC_IRQ_ROT] = rot_q && !rot_prev_r;
        irq_set[`SMTC_IRQ_LIM] = lim_q && !lim_prev_r;
        irq_set[`SMTC_IRQ_REJ] = wr_fire && wr_hit && wr_reject;
        irq_clr                 = '0;
        if (wr_fire && (awaddr_r == `SMTC_OFF_IRQ_STAT) && wstrb_r[0]) begin
            irq_clr = wdata_r[`SMTC_IRQ_W-1:0];
        end
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
    end

    // Status, mask and output
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            rot_prev_r <= 1'b0;
            lim_prev_r <= 1'b0;
            IRQ_O      <= 1'b0;
        end else if (CE_I) begin
            irq_stat_r <= irq_stat_nxt;
            rot_prev_r <= rot_q;
            lim_prev_r <= lim_q;
            if (wr_fire && (awaddr_r == `SMTC_OFF_IRQ_MASK) && wstrb_r[0]) begin
                irq_mask_r <= wdata_r[`SMTC_IRQ_W-1:0];
            end
            IRQ_O <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    // Read mux
    always_comb begin
        status.estop    = ESTOP_O;
        status.servo_on = SERVO_ON_I;
        status.lim_det  = lim_q;
        status.rot_det  = rot_q;
        rd_hit          = 1'b1;
        rd_word         = 32'h00000000;
        case (S_AXI_ARADDR_I)
            `SMTC_OFF_CFG:       rd_word = {28'h0000000, cfg_r};
            `SMTC_OFF_ROT_LVL:   rd_word = {16'h0000, rot_lvl_r};
            `SMTC_OFF_SPD_LIM:   rd_word = {16'h0000, spd_lim_r};
            `SMTC_OFF_TRQ_GAIN:  rd_word = {16'h0000, trq_gain_r};
            `SMTC_OFF_MOTOR_MAX: rd_word = {16'h0000, spd_lim_r};
            `SMTC_OFF_STATUS:    rd_word = {28'h0000000, status};
            `SMTC_OFF_IRQ_STAT:  rd_word = {29'h00000000, irq_stat_r};
            `SMTC_OFF_IRQ_MASK:  rd_word = {29'h00000000, irq_mask_r};
            `SMTC_OFF_SPD_OUT:   rd_word = {{16{SPEED_CMD_O[15]}}, SPEED_CMD_O};
            `SMTC_OFF_TRQ_OUT:   rd_word = {{16{TORQUE_CMD_O[15]}}, TORQUE_CMD_O};
            default:             rd_hit  = 1'b0;
        endcase
    end

    // Address taken when idle, data returned the next cycle
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rd_st_r         <= smtc_pkg::SMTC_CH_IDLE;
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h00000000;
            S_AXI_RRESP_O   <= `SMTC_RESP_OKAY;
        end else if (CE_I) begin
            case (rd_st_r)
                smtc_pkg::SMTC_CH_IDLE: begin
                    S_AXI_ARREADY_O <= 1'b1;
                    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                        rd_st_r         <= smtc_pkg::SMTC_CH_RESP;
                        S_AXI_ARREADY_O <= 1'b0;
                        S_AXI_RVALID_O  <= 1'b1;
                        S_AXI_RDATA_O   <= rd_word;
                        S_AXI_RRESP_O   <= rd_hit ? `SMTC_RESP_OKAY : `SMTC_RESP_SLVERR;
                    end
                end
                smtc_pkg::SMTC_CH_RESP: begin
                    if (S_AXI_RREADY_I) begin
                        rd_st_r        <= smtc_pkg::SMTC_CH_IDLE;
                        S_AXI_RVALID_O <= 1'b0;
                    end
                end
                default: begin
                    rd_st_r <= smtc_pkg::SMTC_CH_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== sim/smtc_checker.sv
// Port-level assertions for the speed monitor block
`timescale 1ns/100ps

module smtc_checker (
    // Clock, reset, loop side
    input wire logic               CLK_I,
    input wire logic               SRST_I,
    input wire logic               CE_I,
    input wire logic               LOOP_TICK_I,
    input wire logic               ESTOP_I,
    input wire logic signed [15:0] SPEED_MEAS_I,
    input wire logic               ROT_DETECT_O,
    input wire logic               SPD_LIMIT_DETECT_O,
    input wire logic               ESTOP_O,
    input wire logic signed [15:0] SPEED_CMD_O,
    // Bus handshakes
    input wire logic               S_AXI_AWVALID_I,
    input wire logic               S_AXI_AWREADY_O,
    input wire logic               S_AXI_WVALID_I,
    input wire logic               S_AXI_WREADY_O,
    input wire logic               S_AXI_BVALID_O,
    input wire logic               S_AXI_ARVALID_I,
    input wire logic               S_AXI_ARREADY_O,
    input wire logic               S_AXI_RVALID_O,
    input wire logic               S_AXI_RREADY_I
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    ////////////////////////////////////////////////////////////////////////////////
    // Detect and speed command outputs move only after a tick; stop output needs its input
    chk_rot_hold: assert property (!(LOOP_TICK_I && CE_I) |=> $stable(ROT_DETECT_O))
        else $error("rotation detect moved without a tick");
    chk_lim_hold: assert property (!(LOOP_TICK_I && CE_I) |=> $stable(SPD_LIMIT_DETECT_O))
        else $error("limit detect moved without a tick");
    chk_cmd_hold: assert property (!(LOOP_TICK_I && CE_I) |=> $stable(SPEED_CMD_O))
        else $error("speed command moved without a tick");
    chk_rot_still: assert property (LOOP_TICK_I && CE_I && SPEED_MEAS_I == 16'h0000
        |=> !ROT_DETECT_O)
        else $error("rotation detect at standstill");
    chk_estop_gate: assert property (CE_I && !ESTOP_I |=> !ESTOP_O)
        else $error("stop output without stop input");

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer timing
    chk_wr_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
        && S_AXI_WREADY_O && CE_I |-> ##2 S_AXI_BVALID_O)
        else $error("write response late");
    chk_rd_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && CE_I
        |=> S_AXI_RVALID_O)
        else $error("read response late");
    chk_rd_done: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I && CE_I |=> !S_AXI_RVALID_O)
        else $error("read response not retired");
endmodule

bind smtc_top smtc_checker chk_i (.*);

// ===== sim/smtc_host_model.sv
// Host controller model: loop strobe and analog torque command
`timescale 1ns/100ps

module smtc_host_model (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               srst_i,
    // Requested torque voltage in millivolts
    input  wire logic signed [15:0] trq_set_i,
    // Drive side
    output logic                    tick_o,
    output logic signed [15:0]      trq_mv_o
);
    logic [1:0] cnt_r;

    // Loop strobe every fourth cycle
    always_ff @(posedge clk_i) begin
        cnt_r  <= srst_i ? 2'h0 : cnt_r + 2'h1;
        tick_o <= !srst_i && cnt_r == 2'h3;
    end

    // Differential command voltage, held at or below +10 V
    always_ff @(posedge clk_i) begin
        trq_mv_o <= (trq_set_i > 16'sh2710) ? 16'sh2710 : trq_set_i;
    end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the speed monitor and torque command block
`timescale 1ns/100ps
`include "smtc_cfg.svh"

module tb_top;
    logic               CLK_I, SRST_I, LOOP_TICK_I, SERVO_ON_I, ESTOP_I, IRQ_O;
    logic               CE_I = 1'b1;
    logic               ROT_DETECT_O, SPD_LIMIT_DETECT_O, ESTOP_O;
    logic signed [15:0] SPEED_MEAS_I, SPEED_CMD_I, TORQUE_MV_I, SPEED_CMD_O, TORQUE_CMD_O;
    logic signed [15:0] trq_set;
    logic        [15:0] HOST_LIMIT_I;
    logic        [7:0]  S_AXI_AWADDR_I, S_AXI_ARADDR_I;
    logic        [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O;
    logic        [3:0]  S_AXI_WSTRB_I = 4'hF;
    logic        [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O, resp;
    logic               S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O;
    logic               S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O;
    logic               S_AXI_RVALID_O, S_AXI_RREADY_I;
    int                 num_errors, tests_run;

    smtc_top dut (.*);
    smtc_host_model host (.clk_i(CLK_I), .srst_i(SRST_I), .trq_set_i(trq_set),
                          .tick_o(LOOP_TICK_I), .trq_mv_o(TORQUE_MV_I));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        S_AXI_AWADDR_I  <= a;
        S_AXI_WDATA_I   <= d;
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I  <= 1'b1;
        S_AXI_BREADY_I  <= 1'b1;
        repeat (100) begin
            @(posedge CLK_I);
            if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
            if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
            if (S_AXI_BVALID_O) break;
        end
        chk("bresp", {S_AXI_BVALID_O, S_AXI_BRESP_O}, {1'b1, `SMTC_RESP_OKAY});
        S_AXI_BREADY_I <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK_I);
        S_AXI_ARADDR_I  <= a;
        S_AXI_ARVALID_I <= 1'b1;
        S_AXI_RREADY_I  <= 1'b1;
        repeat (100) begin
            @(posedge CLK_I);
            if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
            if (S_AXI_RVALID_O) begin
                resp = S_AXI_RRESP_O;
                chk(n, S_AXI_RDATA_O, e);
                break;
            end
        end
        chk("rvalid", S_AXI_RVALID_O, 1'b1);
        S_AXI_RREADY_I <= 1'b0;
    endtask
    task automatic loops;
        repeat (12) @(posedge CLK_I);
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rd("rot_lvl", `SMTC_OFF_ROT_LVL, 32'h14);
        rd("spd_lim", `SMTC_OFF_SPD_LIM, 32'h1388);
        rd("gain", `SMTC_OFF_TRQ_GAIN, 32'hD02);
        rd("cfg", `SMTC_OFF_CFG, 32'h0);
        rd("hole", 8'h28, 32'h0);
        chk("hole_resp", resp, `SMTC_RESP_SLVERR);
    endtask
    task automatic t_rot;
        SPEED_MEAS_I <= 16'h0014;
        loops;
        chk("rot_at_lvl", ROT_DETECT_O, 1'b0);
        SPEED_MEAS_I <= 16'hFFEB;
        loops;
        chk("rot_neg", ROT_DETECT_O, 1'b1);
    endtask
    task automatic t_lim;
        wr(`SMTC_OFF_SPD_LIM, 32'h5DC);
        SPEED_CMD_I  <= 16'h07D0;
        SPEED_MEAS_I <= 16'h05DC;
        loops;
        chk("clamp", SPEED_CMD_O, 32'h5DC);
        chk("lim_eq", SPD_LIMIT_DETECT_O, 1'b1);
        SERVO_ON_I <= 1'b1;
        wr(`SMTC_OFF_SPD_LIM, 32'h3E8);
        rd("lim_servo_on", `SMTC_OFF_SPD_LIM, 32'h5DC);
        rd("irq_stat", `SMTC_OFF_IRQ_STAT, 32'h7);
        wr(`SMTC_OFF_IRQ_MASK, 32'h4);
        loops;
        chk("irq_on", IRQ_O, 1'b1);
        wr(`SMTC_OFF_IRQ_STAT, 32'h7);
        loops;
        chk("irq_off", IRQ_O, 1'b0);
        SERVO_ON_I <= 1'b0;
        wr(`SMTC_OFF_SPD_LIM, 32'h1771);
        rd("lim_range", `SMTC_OFF_SPD_LIM, 32'h5DC);
    endtask
    task automatic t_setup;
        wr(`SMTC_OFF_MOTOR_MAX, 32'hBB8);
        rd("motor_max", `SMTC_OFF_SPD_LIM, 32'hBB8);
        loops;
        chk("lim_below", SPD_LIMIT_DETECT_O, 1'b0);
    endtask
    task automatic t_host;
        HOST_LIMIT_I <= 16'h0320;
        wr(`SMTC_OFF_CFG, 32'h4);
        loops;
        chk("host_clamp", SPEED_CMD_O, 32'h320);
        wr(`SMTC_OFF_SPD_LIM, 32'h64);
        loops;
        chk("param_ignored", SPEED_CMD_O, 32'h320);
    endtask
    task automatic t_trq;
        trq_set <= 16'h0BB8;
        wr(`SMTC_OFF_CFG, 32'h2);
        loops;
        chk("torque", TORQUE_CMD_O, 32'h3E7);
        wr(`SMTC_OFF_CFG, 32'h0);
        loops;
        chk("torque_off", TORQUE_CMD_O, 32'h0);
    endtask
    task automatic t_estop;
        ESTOP_I <= 1'b1;
        loops;
        chk("estop_ignored", ESTOP_O, 1'b0);
        wr(`SMTC_OFF_CFG, 32'h8);
        loops;
        chk("estop_used", ESTOP_O, 1'b1);
        {CE_I, ESTOP_I} <= 2'h0;
        loops;
        chk("ce", ESTOP_O, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end
    initial begin
        repeat (20000) @(posedge CLK_I);
        num_errors++;
        wrap_up;
    end
    initial begin
        {SRST_I, SERVO_ON_I, ESTOP_I, S_AXI_AWVALID_I, S_AXI_WVALID_I} = 5'h10;
        {S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} = 3'h0;
        {SPEED_MEAS_I, SPEED_CMD_I, HOST_LIMIT_I, trq_set} = 64'h0;
        {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I} = 48'h0;
        repeat (10) @(posedge CLK_I);
        SRST_I <= 1'b0;
        t_reset;
        t_rot;
        t_lim;
        t_setup;
        t_host;
        t_trq;
        t_estop;
        wrap_up;
    end
endmodule
